/* inc/lews_map.svh */
// lews_map.svh: encodings and constants for the write lane steering block
// assumes: included by bare name from the design files
`ifndef LEWS_MAP_SVH
`define LEWS_MAP_SVH
`define LEWS_HSIZE_BYTE  3'h0
`define LEWS_HSIZE_HALF  3'h1
`define LEWS_HSIZE_WORD  3'h2
`define LEWS_WIDTH_8     2'h0
`define LEWS_WIDTH_16    2'h1
`define LEWS_WIDTH_32    2'h2
`define LEWS_STRB_ALL    4'h0
`define LEWS_STRB_NONE   4'hF
`define LEWS_STRB_HI16   4'h3
`define LEWS_STRB_LO16   4'hC
`define LEWS_STRB2_BOTH  2'h0
`define LEWS_STRB2_HI    2'h1
`define LEWS_STRB2_LO    2'h2
`endif

/* inc/lews_pkg.sv */
// lews_pkg.sv: types for the write lane steering block
// assumes: nothing beyond the map header
package lews_pkg;
	typedef enum logic [1:0] {
		LEWS_IDLE,
		LEWS_BUSY
	} lews_state_e;
endpackage : lews_pkg

/* src/lews_lane_map.sv */
// lews_lane_map.sv: combinational lane map for one external beat
// assumes: beat address is the low external address of the current beat
`timescale 1ns/100ps
`include "lews_map.svh"
module lews_lane_map (
	input  wire logic [1:0]  width_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [1:0]  haddr_in,
	input  wire logic [1:0]  beat_addr_in,
	input  wire logic [31:0] wdata_in,
	output logic      [31:0] ext_data_out,
	output logic      [3:0]  strb_n_out
);
	// byte picker from the write word
	function automatic logic [7:0] pick_byte(input logic [31:0] w,
		input logic [1:0] a);
		pick_byte = w[{a, 3'h0} +: 8];
	endfunction : pick_byte

	// unused lanes carry don't-care data, driven zero on 8- and 16-bit beats; 32-bit beats carry the whole write word
	always_comb begin
		ext_data_out = 32'h0;
		strb_n_out   = `LEWS_STRB_NONE;
		unique case (width_in)
			`LEWS_WIDTH_8: begin
				ext_data_out[7:0] = pick_byte(wdata_in, beat_addr_in);
				strb_n_out        = 4'hE;
			end
			`LEWS_WIDTH_16: begin
				ext_data_out[15:0] = beat_addr_in[1] ? wdata_in[31:16]
					: wdata_in[15:0];
				if (hsize_in == `LEWS_HSIZE_BYTE) begin
					strb_n_out = {2'h3, haddr_in[0] ? `LEWS_STRB2_HI
						: `LEWS_STRB2_LO};
				end else begin
					strb_n_out = {2'h3, `LEWS_STRB2_BOTH};
				end
			end
			default: begin
				ext_data_out = wdata_in;
				unique case (hsize_in)
					`LEWS_HSIZE_WORD: strb_n_out = `LEWS_STRB_ALL;
					`LEWS_HSIZE_HALF: strb_n_out = haddr_in[1]
						? `LEWS_STRB_HI16 : `LEWS_STRB_LO16;
					default: strb_n_out = ~(4'h1 << haddr_in);
				endcase
			end
		endcase
	end
endmodule : lews_lane_map

/* src/lews_write_steer.sv */
// lews_write_steer.sv: splits a little-endian write into external beats
// assumes: one write request at a time; beat_ack paces each external beat;
// shared by the static and dynamic controller paths
`timescale 1ns/100ps
`include "lews_map.svh"
// Overview of operation
// - 8-bit bus word write: four beats, addresses 11..00, bytes high first
// - 8-bit halfword: two beats in the addressed pair, odd byte first; byte: one beat; strobe low
// - 16-bit bus word write: two beats, upper half then lower, strobes 00
// - 16-bit halfword one beat strobes 00; byte uses strobes 01 or 10
// - 32-bit word single beat 0000; halfword 0011 or 1100
// - 32-bit byte write asserts one strobe chosen by address, lane kept
// - same steering serves static and dynamic memory paths
module lews_write_steer (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	input  wire logic        req_valid_in,
	input  wire logic        dyn_path_in,
	input  wire logic [1:0]  width_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [1:0]  haddr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        beat_ack_in,
	output logic             req_ready_out,
	output logic             beat_valid_out,
	output logic             beat_last_out,
	output logic             dyn_path_out,
	output logic [1:0]       ext_addr_low_bits_out,
	output logic [31:0]      ext_data_out,
	output logic [3:0]       byte_lane_strobe_n_out
);
	lews_pkg::lews_state_e state_q, state_d;
	logic [1:0]  addr_q, addr_d;
	logic [1:0]  last_q, last_d;
	logic [1:0]  width_q, width_d;
	logic [2:0]  hsize_q, hsize_d;
	logic [1:0]  haddr_q, haddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic        dyn_q, dyn_d;
	logic [31:0] map_data;
	logic [3:0]  map_strb_n;
	logic [1:0]  first_addr, final_addr;

	// every check below samples on the rising edge and sleeps in reset
	default clocking cb_chk @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// start and end beat address; beats count downward like the tables
	always_comb begin
		first_addr = haddr_in;
		final_addr = haddr_in;
		if (width_in == `LEWS_WIDTH_8) begin
			if (hsize_in == `LEWS_HSIZE_WORD) begin
				first_addr = 2'h3;
				final_addr = 2'h0;
			end else if (hsize_in == `LEWS_HSIZE_HALF) begin
				first_addr = {haddr_in[1], 1'b1};
				final_addr = {haddr_in[1], 1'b0};
			end
		end else if (width_in == `LEWS_WIDTH_16) begin
			if (hsize_in == `LEWS_HSIZE_WORD) begin
				first_addr = 2'h2;
				final_addr = 2'h0;
			end else begin
				first_addr = {haddr_in[1], 1'b0};
				final_addr = {haddr_in[1], 1'b0};
			end
		end
	end

	// next-state: capture on request, step on each acknowledged beat
	always_comb begin
		state_d = state_q;
		addr_d  = addr_q;
		last_d  = last_q;
		width_d = width_q;
		hsize_d = hsize_q;
		haddr_d = haddr_q;
		wdata_d = wdata_q;
		dyn_d   = dyn_q;
		unique case (state_q)
			lews_pkg::LEWS_IDLE: begin
				if (req_valid_in) begin
					state_d = lews_pkg::LEWS_BUSY;
					addr_d  = first_addr;
					last_d  = final_addr;
					width_d = width_in;
					hsize_d = hsize_in;
					haddr_d = haddr_in;
					wdata_d = wdata_in;
					dyn_d   = dyn_path_in;
				end
			end
			lews_pkg::LEWS_BUSY: begin
				if (beat_ack_in) begin
					if (addr_q == last_q) begin
						state_d = lews_pkg::LEWS_IDLE;
					end else if (width_q == `LEWS_WIDTH_16) begin
						addr_d = addr_q - 2'h2;
					end else begin
						addr_d = addr_q - 2'h1;
					end
				end
			end
		endcase
	end

	// all state freezes while the clock enable is low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= lews_pkg::LEWS_IDLE;
			addr_q  <= 2'h0;
			last_q  <= 2'h0;
			width_q <= 2'h0;
			hsize_q <= 3'h0;
			haddr_q <= 2'h0;
			wdata_q <= 32'h0;
			dyn_q   <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			addr_q  <= addr_d;
			last_q  <= last_d;
			width_q <= width_d;
			hsize_q <= hsize_d;
			haddr_q <= haddr_d;
			wdata_q <= wdata_d;
			dyn_q   <= dyn_d;
		end
	end

	lews_lane_map u_map (
		.width_in     (width_q),
		.hsize_in     (hsize_q),
		.haddr_in     (haddr_q),
		.beat_addr_in (addr_q),
		.wdata_in     (wdata_q),
		.ext_data_out (map_data),
		.strb_n_out   (map_strb_n)
	);

	// beat outputs come from registered state; strobes idle high
	always_comb begin
		req_ready_out          = (state_q == lews_pkg::LEWS_IDLE);
		beat_valid_out         = (state_q == lews_pkg::LEWS_BUSY);
		beat_last_out          = beat_valid_out && (addr_q == last_q);
		dyn_path_out           = dyn_q;
		ext_addr_low_bits_out  = addr_q;
		ext_data_out           = map_data;
		byte_lane_strobe_n_out = beat_valid_out ? map_strb_n
			: `LEWS_STRB_NONE;
	end

	// an accepted 8-bit word opens at the top byte address
	AST_W8_WORD_FOUR: assert property (
		clk_en_in && req_ready_out && req_valid_in
		&& width_in == `LEWS_WIDTH_8 && hsize_in == `LEWS_HSIZE_WORD
		|=> ext_addr_low_bits_out == 2'h3)
		else $error("8-bit word write does not start at address 3");
	// each 8-bit beat puts the addressed byte on the low lane
	AST_W8_LANE: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_8
		|-> ext_data_out[7:0] == wdata_q[{ext_addr_low_bits_out, 3'h0} +: 8]
		&& byte_lane_strobe_n_out == 4'hE)
		else $error("8-bit beat carries wrong byte or strobe");
	// accepted 8-bit beats step one byte address downward
	AST_W8_STEP: assert property (
		beat_valid_out && !beat_last_out && beat_ack_in && clk_en_in
		&& width_q == `LEWS_WIDTH_8
		|=> ext_addr_low_bits_out == $past(ext_addr_low_bits_out) - 2'h1)
		else $error("8-bit beat address did not step down by one");
	// an 8-bit halfword stays inside its own byte pair
	AST_W8_HALF: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_8
		&& hsize_q == `LEWS_HSIZE_HALF
		|-> ext_addr_low_bits_out[1] == haddr_q[1])
		else $error("8-bit halfword beat left its byte pair");
	// an 8-bit byte write is one beat at its own address
	AST_W8_BYTE: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_8
		&& hsize_q == `LEWS_HSIZE_BYTE
		|-> ext_addr_low_bits_out == haddr_q && beat_last_out)
		else $error("8-bit byte write not one beat at its address");
	// 16-bit word beats put the addressed half on the low lanes
	AST_W16_WORD: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_16
		&& hsize_q == `LEWS_HSIZE_WORD
		|-> byte_lane_strobe_n_out == {2'h3, `LEWS_STRB2_BOTH}
		&& ext_data_out[15:0] == (ext_addr_low_bits_out[1]
		? wdata_q[31:16] : wdata_q[15:0]))
		else $error("16-bit word beat wrong");
	// a 16-bit halfword is one beat with both strobes on
	AST_W16_HALF: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_16
		&& hsize_q == `LEWS_HSIZE_HALF
		|-> byte_lane_strobe_n_out == {2'h3, `LEWS_STRB2_BOTH}
		&& ext_addr_low_bits_out == {haddr_q[1], 1'b0} && beat_last_out)
		else $error("16-bit halfword beat wrong");
	// a 16-bit byte enables only the lane that holds it
	AST_W16_BYTE: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_16
		&& hsize_q == `LEWS_HSIZE_BYTE
		|-> byte_lane_strobe_n_out[1:0] == (haddr_q[0] ? 2'h1 : 2'h2))
		else $error("16-bit byte strobes wrong");
	// a 32-bit word is a single unswapped beat with all strobes on
	AST_W32_WORD: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_32
		&& hsize_q == `LEWS_HSIZE_WORD
		|-> byte_lane_strobe_n_out == 4'h0 && beat_last_out
		&& ext_data_out == wdata_q)
		else $error("32-bit word not one unswapped beat");
	// a 32-bit halfword enables the half that its address names
	AST_W32_HALF: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_32
		&& hsize_q == `LEWS_HSIZE_HALF
		|-> byte_lane_strobe_n_out == (haddr_q[1] ? 4'h3 : 4'hC)
		&& beat_last_out && ext_data_out == wdata_q)
		else $error("32-bit halfword strobes wrong");
	// a 32-bit byte enables one strobe and keeps its own lane
	AST_W32_BYTE: assert property (
		beat_valid_out && width_q == `LEWS_WIDTH_32
		&& hsize_q == `LEWS_HSIZE_BYTE
		|-> $countones(~byte_lane_strobe_n_out) == 1
		&& !byte_lane_strobe_n_out[haddr_q]
		&& beat_last_out && ext_data_out == wdata_q)
		else $error("32-bit byte strobe wrong");
	// the captured path may not change between beats of one write
	AST_PATH_HELD: assert property (
		beat_valid_out && !beat_last_out && clk_en_in && beat_ack_in
		|=> beat_valid_out && $stable(dyn_path_out))
		else $error("path changed within a burst");
	// no strobe is driven without a beat on the bus
	AST_IDLE_STRB: assert property (
		!beat_valid_out |-> byte_lane_strobe_n_out == 4'hF)
		else $error("strobe active while idle");
	// the last acknowledged beat drops strobes and frees the request side
	AST_ACK_DONE: assert property (
		beat_valid_out && beat_last_out && beat_ack_in && clk_en_in
		|=> req_ready_out && byte_lane_strobe_n_out == 4'hF)
		else $error("block did not return to idle after the last beat");
endmodule : lews_write_steer

/* tb/lews_mem_model.sv */
// lews_mem_model.sv: external memory stand-in that accepts write beats
// assumes: beat valid comes from the steering block, stall set by bench
`timescale 1ns/100ps
module lews_mem_model (
	input  wire logic       clk_in,
	input  wire logic       beat_valid_in,
	input  wire logic [1:0] stall_in,
	output logic            beat_ack_out
);
	logic [1:0] cnt_q;
	// a slow device waits stall_in cycles and never acks two beats in a row; with stall_in zero it acks every cycle
	always @(negedge clk_in) begin
		beat_ack_out <= beat_valid_in && (stall_in == 2'h0 ||
			(!beat_ack_out && cnt_q >= stall_in));
		cnt_q <= (beat_valid_in && !beat_ack_out) ? cnt_q + 2'h1 : 2'h0;
	end
endmodule : lews_mem_model

/* tb/tb.sv */
// tb.sv: self-checking bench for the little-endian write steering block
// assumes: memory model acks beats; inputs change at the falling edge
`timescale 1ns/100ps
module tb;
	logic        clk_in = 0, rst_n_in = 0, clk_en_in = 1;
	logic        req_valid_in = 0, dyn_path_in = 0, beat_ack_in;
	logic [1:0]  width_in = 0, haddr_in = 0, stall = 0, ext_addr;
	logic [2:0]  hsize_in = 0;
	logic [31:0] wdata_in = 0, ext_data;
	logic [3:0]  strb_n;
	logic        ready, valid, last, dyn;
	int          failures = 0, n_checks = 0;

	lews_write_steer uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in), .req_valid_in(req_valid_in),
		.dyn_path_in(dyn_path_in), .width_in(width_in),
		.hsize_in(hsize_in), .haddr_in(haddr_in), .wdata_in(wdata_in),
		.beat_ack_in(beat_ack_in), .req_ready_out(ready),
		.beat_valid_out(valid), .beat_last_out(last),
		.dyn_path_out(dyn), .ext_addr_low_bits_out(ext_addr),
		.ext_data_out(ext_data), .byte_lane_strobe_n_out(strb_n));
	lews_mem_model mem (.clk_in(clk_in), .beat_valid_in(valid),
		.stall_in(stall), .beat_ack_out(beat_ack_in));

	initial forever #50 clk_in = ~clk_in;

	task automatic chk(input logic [31:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// expected beat i: count, low address, strobes and lane data
	function automatic void exb(input logic [1:0] w, ha, input logic [2:0] hs,
		input logic [31:0] wd, input int i, output int nb,
		output logic [1:0] ea, output logic [3:0] es, output logic [31:0] ed);
		logic b;
		b = (hs == 3'h2) ? ~i[0] : ha[1];
		nb = 1;
		ea = {b, 1'b0};
		es = 4'hC;
		ed = {16'h0, wd[16*b+:16]};
		if (w == 2'h0) begin
			nb = hs == 3'h2 ? 4 : hs == 3'h1 ? 2 : 1;
			ea = hs == 3'h2 ? 2'(3 - i) : hs == 3'h1 ? {ha[1], ~i[0]} : ha;
			es = 4'hE;
			ed = {24'h0, wd[8*ea+:8]};
		end else if (w == 2'h1) begin
			nb = hs == 3'h2 ? 2 : 1;
			if (hs == 3'h0) es = ha[0] ? 4'hD : 4'hE;
		end else begin
			es = hs == 3'h2 ? 4'h0 : hs == 3'h1 ? (ha[1] ? 4'h3 : 4'hC)
				: ~(4'h1 << ha);
			ed = wd;
		end
	endfunction : exb

	// one write; hold keeps a second request up while busy, to be refused
	task automatic wr(input logic [1:0] w, a, input logic [2:0] h,
		input logic [31:0] d, input logic p, hold);
		int nb, k, n;
		logic [1:0] ea;
		logic [3:0] es;
		logic [31:0] ed, m;
		exb(w, a, h, d, 0, nb, ea, es, ed);
		@(negedge clk_in);
		{req_valid_in, width_in, hsize_in, haddr_in} = {1'b1, w, h, a};
		{wdata_in, dyn_path_in} = {d, p};
		@(posedge clk_in);
		@(negedge clk_in);
		req_valid_in = hold;
		wdata_in = ~d;
		k = 0;
		n = 0;
		while (k < nb && n < 60) begin
			@(posedge clk_in);
			n++;
			if (valid && beat_ack_in && clk_en_in) begin
				exb(w, a, h, d, k, nb, ea, es, ed);
				m = {{8{~es[3]}}, {8{~es[2]}}, {8{~es[1]}}, {8{~es[0]}}};
				chk(strb_n, es, "strb");
				chk(ext_data & m, ed & m, "data");
				if (w != 2'h2) chk(ext_addr, ea, "addr");
				chk(last, k == nb - 1, "last");
				chk({dyn, ready}, {p, 1'b0}, "path");
				k++;
			end
		end
		@(negedge clk_in);
		req_valid_in = 0;
		chk(n < 60, 1, "beats");
		chk({ready, valid, strb_n}, 6'h2F, "idle");
	endtask : wr

	task automatic t_width(input logic [1:0] w, s, input logic p);
		stall = s;
		for (int h = 0; h < 3; h++)
			for (int a = 0; a < 4; a++)
				wr(w, 2'(a), 3'(h), 32'hA1B2C3D4 ^ a, p, 0);
		$display("width test %0d done", w);
	endtask : t_width

	// refused request while busy, then a clock-enable freeze mid-write
	task automatic t_busy_frz;
		stall = 2'h1;
		wr(2'h0, 2'h0, 3'h2, 32'h0F1E2D3C, 1, 1);
		fork
			wr(2'h1, 2'h0, 3'h2, 32'h96875A4B, 0, 0);
			begin
				repeat (3) @(negedge clk_in);
				clk_en_in = 0;
				repeat (3) @(negedge clk_in);
				clk_en_in = 1;
			end
		join
		$display("busy and freeze test done");
	endtask : t_busy_frz

	// reset in mid-burst returns every output to idle, then writes resume
	task automatic t_reset;
		stall = 2'h2;
		@(negedge clk_in);
		{req_valid_in, width_in, hsize_in, haddr_in} = {1'b1, 2'h0, 3'h2, 2'h0};
		{wdata_in, dyn_path_in} = {32'h5A6B7C8D, 1'b1};
		@(negedge clk_in);
		req_valid_in = 0;
		chk({ready, valid, strb_n, ext_addr}, 8'h7B, "busy");
		rst_n_in = 0;
		@(negedge clk_in);
		chk({ready, valid, strb_n, ext_addr, dyn}, 9'h178, "rst");
		chk(ext_data, 32'h0, "rst data");
		rst_n_in = 1;
		wr(2'h0, 2'h1, 3'h1, 32'h13579BDF, 0, 0);
		wr(2'h2, 2'h2, 3'h3, 32'h2468ACE0, 1, 0);
		$display("reset test done");
	endtask : t_reset

	task automatic conclude;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude

	initial begin
		repeat (3) @(negedge clk_in);
		rst_n_in = 1;
		t_width(2'h0, 2'h0, 0);
		t_width(2'h1, 2'h2, 1);
		t_width(2'h2, 2'h1, 0);
		t_busy_frz;
		t_reset;
		conclude;
	end

	// whole run needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		failures++;
		conclude;
	end
endmodule : tb
